/* hdl/dfsc_defines.svh */
// constants for the decimation filter stage control block
`ifndef DFSC_DEFINES_SVH
`define DFSC_DEFINES_SVH

`define DFSC_SAMPLE_W     16
`define DFSC_STAGES       9
`define DFSC_ADDR_W       12

// register indices as printed, byte address is four times the index
`define DFSC_IDX_DSPP     8'h79
`define DFSC_IDX_FIRST    8'h7A
`define DFSC_IDX_A_UPPER  8'h7B
`define DFSC_IDX_B        8'h7C
`define DFSC_ADDR_MODE    12'h000
`define DFSC_ADDR_STATUS  12'h004
`define DFSC_ADDR_DSPP    ({4'h0, `DFSC_IDX_DSPP} << 2)
`define DFSC_ADDR_FIRST   ({4'h0, `DFSC_IDX_FIRST} << 2)
`define DFSC_ADDR_A_UPPER ({4'h0, `DFSC_IDX_A_UPPER} << 2)
`define DFSC_ADDR_B       ({4'h0, `DFSC_IDX_B} << 2)

// field positions
`define DFSC_DSPP_EN_BIT  7
`define DFSC_FIRST_BIT    6

// reset values
`define DFSC_RST_BYTE     8'h00
`define DFSC_RST_MODE     2'h0

// mode field encodings
`define DFSC_MODE_SINGLE  2'h0
`define DFSC_MODE_DUAL    2'h1

// bus responses
`define DFSC_RESP_OKAY    2'h0
`define DFSC_RESP_SLVERR  2'h2

`endif

/* hdl/dfsc_pkg.sv */
// types shared by the decimation filter stage control files
`include "dfsc_defines.svh"
package dfsc_pkg;
    typedef logic [`DFSC_SAMPLE_W-1:0] dfsc_sample_t;
    typedef enum logic [1:0] {DFSC_SINGLE, DFSC_DUAL, DFSC_OTHER} dfsc_mode_t;
    // one buffered word: a lane flag with each chain's sample
    typedef struct packed {
        logic         a_valid;
        dfsc_sample_t a;
        logic         b_valid;
        dfsc_sample_t b;
    } dfsc_word_t;
endpackage

/* hdl/dfsc_stream_if.sv */
// stream link between the filter chains and the output buffer
`timescale 1ns/10ps
interface dfsc_stream_if;
    dfsc_pkg::dfsc_word_t data;
    logic                 valid;
    logic                 ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface // dfsc_stream_if

/* hdl/dfsc_pair_buffer.sv */
// two-entry output buffer, head entry drives the outputs directly
`timescale 1ns/10ps
`include "dfsc_defines.svh"
module dfsc_pair_buffer (
    // clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // filling side
    dfsc_stream_if.snk            fill,
    // draining side
    output logic                  drain_valid,
    input  wire logic             drain_ready,
    output dfsc_pkg::dfsc_word_t  drain_data
);
    dfsc_pkg::dfsc_word_t head_r, head_nxt, tail_r, tail_nxt;
    logic [1:0]           cnt_r, cnt_nxt;
    logic                 valid_r, valid_nxt, ready_r, ready_nxt;
    logic                 push, pop;

    assign fill.ready  = ready_r;
    assign drain_valid = valid_r;
    assign drain_data  = head_r;

    // ready is a flop so the source never sees a gate on it
    always_comb begin
        push     = fill.valid && ready_r;
        pop      = valid_r && drain_ready;
        head_nxt = head_r;
        tail_nxt = tail_r;
        if (pop) begin
            head_nxt = (cnt_r == 2'h2) ? tail_r : fill.data;
        end
        if (push) begin
            if (cnt_r == 2'h0 || (cnt_r == 2'h1 && pop)) begin
                head_nxt = fill.data;
            end else begin
                tail_nxt = fill.data;
            end
        end
        cnt_nxt   = cnt_r + {1'b0, push} - {1'b0, pop};
        valid_nxt = (cnt_nxt != 2'h0);
        ready_nxt = (cnt_nxt != 2'h2);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            head_r  <= '0;
            tail_r  <= '0;
            cnt_r   <= 2'h0;
            valid_r <= 1'b0;
            ready_r <= 1'b0;
        end else begin
            head_r  <= head_nxt;
            tail_r  <= tail_nxt;
            cnt_r   <= cnt_nxt;
            valid_r <= valid_nxt;
            ready_r <= ready_nxt;
        end
    end
endmodule // dfsc_pair_buffer

/* hdl/dfsc_top.sv */
// decimation filter stage control: register slave, two halving chains, output buffer
`timescale 1ns/10ps
`include "dfsc_defines.svh"
module dfsc_top (
    // clock and reset
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    // axi4-lite write
    input  wire logic [`DFSC_ADDR_W-1:0]   awaddr,
    input  wire logic                      awvalid,
    output logic                           awready,
    input  wire logic [31:0]               wdata,
    input  wire logic [3:0]                wstrb,
    input  wire logic                      wvalid,
    output logic                           wready,
    output logic [1:0]                     bresp,
    output logic                           bvalid,
    input  wire logic                      bready,
    // axi4-lite read
    input  wire logic [`DFSC_ADDR_W-1:0]   araddr,
    input  wire logic                      arvalid,
    output logic                           arready,
    output logic [31:0]                    rdata,
    output logic [1:0]                     rresp,
    output logic                           rvalid,
    input  wire logic                      rready,
    // samples from the converter core
    input  wire logic                      in_valid,
    input  wire dfsc_pkg::dfsc_sample_t    in_sample_a,
    input  wire dfsc_pkg::dfsc_sample_t    in_sample_b,
    output logic                           in_ready,
    // decimated samples
    output logic                           out_valid,
    input  wire logic                      out_ready,
    output logic                           out_a_valid,
    output dfsc_pkg::dfsc_sample_t         out_sample_a,
    output logic                           out_b_valid,
    output dfsc_pkg::dfsc_sample_t         out_sample_b
);
    // configuration registers
    logic [1:0] mode_r, mode_nxt;
    logic [7:0] dspp_r, dspp_nxt, first_r, first_nxt, a_up_r, a_up_nxt, b_r, b_nxt;
    // bus state
    logic [`DFSC_ADDR_W-1:0] awaddr_r, awaddr_nxt;
    logic [31:0]             wdata_r, wdata_nxt, rdata_nxt;
    logic [3:0]              wstrb_r, wstrb_nxt;
    logic                    aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
    logic                    awready_nxt, wready_nxt, arready_nxt, bvalid_nxt, rvalid_nxt;
    logic [1:0]              bresp_nxt, rresp_nxt;
    logic                    aw_fire, w_fire, ar_fire, do_wr;
    // chain control
    dfsc_pkg::dfsc_mode_t    mode;
    logic [8:0]              code_a, en_a, en_b;
    logic [3:0]              cnt_a, cnt_b;
    logic                    fire;
    wire                     ch_v [0:1][0:9];
    dfsc_pkg::dfsc_sample_t  ch_d [0:1][0:9];
    dfsc_pkg::dfsc_word_t    drain_word;
    dfsc_stream_if           to_buf ();

    // mode decode, undefined codes fall to the bypass mode
    always_comb begin
        unique case (mode_r)
            `DFSC_MODE_SINGLE: mode = dfsc_pkg::DFSC_SINGLE;
            `DFSC_MODE_DUAL:   mode = dfsc_pkg::DFSC_DUAL;
            default:           mode = dfsc_pkg::DFSC_OTHER;
        endcase
    end

    // effective stage enables; patterns are used bit for bit, no pattern check
    always_comb begin
        code_a = {a_up_r, first_r[`DFSC_FIRST_BIT]};
        en_a   = 9'h000;
        en_b   = 9'h000;
        unique case (mode)
            dfsc_pkg::DFSC_SINGLE: en_a = code_a;
            dfsc_pkg::DFSC_DUAL: begin
                if (dspp_r[`DFSC_DSPP_EN_BIT]) begin
                    en_a = {code_a[8:1], 1'b0};
                    en_b = {b_r, 1'b0};
                end
            end
            dfsc_pkg::DFSC_OTHER: ;
        endcase
        cnt_a = 4'h0;
        cnt_b = 4'h0;
        for (int i = 0; i < `DFSC_STAGES; i++) begin
            cnt_a = cnt_a + {3'h0, en_a[i]};
            cnt_b = cnt_b + {3'h0, en_b[i]};
        end
    end

    // chain inputs; chain b idles in single-channel mode
    assign fire        = in_valid && in_ready;
    assign ch_v[0][0]  = fire;
    assign ch_v[1][0]  = fire && (mode != dfsc_pkg::DFSC_SINGLE);
    assign ch_d[0][0]  = in_sample_a;
    assign ch_d[1][0]  = in_sample_b;

    // each enabled stage averages a pair and emits one word per two
    for (genvar c = 0; c < 2; c++) begin : g_ch
        for (genvar s = 0; s < `DFSC_STAGES; s++) begin : g_st
            logic                   ph_r, ph_nxt, vo;
            dfsc_pkg::dfsc_sample_t hold_r, hold_nxt, dout;
            logic [`DFSC_SAMPLE_W:0] sum;
            logic                   en;
            assign en = (c == 0) ? en_a[s] : en_b[s];
            always_comb begin
                ph_nxt   = ph_r;
                hold_nxt = hold_r;
                vo       = ch_v[c][s];
                dout     = ch_d[c][s];
                sum      = {ch_d[c][s][`DFSC_SAMPLE_W-1], ch_d[c][s]}
                         + {hold_r[`DFSC_SAMPLE_W-1], hold_r};
                if (!en) begin
                    ph_nxt = 1'b0;
                end else if (ch_v[c][s]) begin
                    if (!ph_r) begin
                        hold_nxt = ch_d[c][s];
                        ph_nxt   = 1'b1;
                        vo       = 1'b0;
                    end else begin
                        dout   = sum[`DFSC_SAMPLE_W:1];
                        ph_nxt = 1'b0;
                    end
                end
            end
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    ph_r   <= 1'b0;
                    hold_r <= '0;
                end else begin
                    ph_r   <= ph_nxt;
                    hold_r <= hold_nxt;
                end
            end
            assign ch_v[c][s+1] = vo;
            assign ch_d[c][s+1] = dout;
        end
    end

    // chain outputs share one buffer word; its ready stalls the input
    assign to_buf.valid        = ch_v[0][9] || ch_v[1][9];
    // one driver for the whole word keeps the packed struct single-sourced
    assign to_buf.data         = '{a_valid: ch_v[0][9], a: ch_d[0][9],
                                   b_valid: ch_v[1][9], b: ch_d[1][9]};
    assign in_ready            = to_buf.ready;

    dfsc_pair_buffer u_buf (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .fill        (to_buf.snk),
        .drain_valid (out_valid),
        .drain_ready (out_ready),
        .drain_data  (drain_word)
    );
    assign out_a_valid  = drain_word.a_valid;
    assign out_sample_a = drain_word.a;
    assign out_b_valid  = drain_word.b_valid;
    assign out_sample_b = drain_word.b;

    // bus slave: address and data taken in either order, write when both held
    always_comb begin
        aw_fire     = awvalid && awready;
        w_fire      = wvalid && wready;
        ar_fire     = arvalid && arready;
        do_wr       = aw_held_r && w_held_r && !bvalid;
        awaddr_nxt  = aw_fire ? awaddr : awaddr_r;
        wdata_nxt   = w_fire ? wdata : wdata_r;
        wstrb_nxt   = w_fire ? wstrb : wstrb_r;
        aw_held_nxt = (aw_held_r || aw_fire) && !do_wr;
        w_held_nxt  = (w_held_r || w_fire) && !do_wr;
        bvalid_nxt  = bvalid && !bready;
        bresp_nxt   = bresp;
        mode_nxt    = mode_r;
        dspp_nxt    = dspp_r;
        first_nxt   = first_r;
        a_up_nxt    = a_up_r;
        b_nxt       = b_r;
        if (do_wr) begin
            bvalid_nxt = 1'b1;
            bresp_nxt  = `DFSC_RESP_OKAY;
            // only byte lane 0 carries register bits
            unique case (awaddr_r)
                `DFSC_ADDR_MODE:    if (wstrb_r[0]) mode_nxt  = wdata_r[1:0];
                `DFSC_ADDR_STATUS:  ;
                `DFSC_ADDR_DSPP:    if (wstrb_r[0]) dspp_nxt  = wdata_r[7:0];
                `DFSC_ADDR_FIRST:   if (wstrb_r[0]) first_nxt = wdata_r[7:0];
                `DFSC_ADDR_A_UPPER: if (wstrb_r[0]) a_up_nxt  = wdata_r[7:0];
                `DFSC_ADDR_B:       if (wstrb_r[0]) b_nxt     = wdata_r[7:0];
                default:            bresp_nxt = `DFSC_RESP_SLVERR;
            endcase
        end
        awready_nxt = !aw_held_nxt;
        wready_nxt  = !w_held_nxt;
        // read answers one edge after the address is taken
        rvalid_nxt  = rvalid && !rready;
        rdata_nxt   = rdata;
        rresp_nxt   = rresp;
        if (ar_fire) begin
            rvalid_nxt = 1'b1;
            rresp_nxt  = `DFSC_RESP_OKAY;
            unique case (araddr)
                `DFSC_ADDR_MODE:    rdata_nxt = {30'h00000000, mode_r};
                `DFSC_ADDR_STATUS:  rdata_nxt = {24'h000000, cnt_b, cnt_a};
                `DFSC_ADDR_DSPP:    rdata_nxt = {24'h000000, dspp_r};
                `DFSC_ADDR_FIRST:   rdata_nxt = {24'h000000, first_r};
                `DFSC_ADDR_A_UPPER: rdata_nxt = {24'h000000, a_up_r};
                `DFSC_ADDR_B:       rdata_nxt = {24'h000000, b_r};
                default: begin
                    rdata_nxt = 32'h00000000;
                    rresp_nxt = `DFSC_RESP_SLVERR;
                end
            endcase
        end
        arready_nxt = !rvalid_nxt;
    end

    // codes come out of reset all-zero so every stage starts bypassed
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_r    <= `DFSC_RST_MODE;
            dspp_r    <= `DFSC_RST_BYTE;
            first_r   <= `DFSC_RST_BYTE;
            a_up_r    <= `DFSC_RST_BYTE;
            b_r       <= `DFSC_RST_BYTE;
            awaddr_r  <= '0;
            wdata_r   <= 32'h00000000;
            wstrb_r   <= 4'h0;
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            awready   <= 1'b0;
            wready    <= 1'b0;
            bvalid    <= 1'b0;
            bresp     <= `DFSC_RESP_OKAY;
            arready   <= 1'b0;
            rvalid    <= 1'b0;
            rdata     <= 32'h00000000;
            rresp     <= `DFSC_RESP_OKAY;
        end else begin
            mode_r    <= mode_nxt;
            dspp_r    <= dspp_nxt;
            first_r   <= first_nxt;
            a_up_r    <= a_up_nxt;
            b_r       <= b_nxt;
            awaddr_r  <= awaddr_nxt;
            wdata_r   <= wdata_nxt;
            wstrb_r   <= wstrb_nxt;
            aw_held_r <= aw_held_nxt;
            w_held_r  <= w_held_nxt;
            awready   <= awready_nxt;
            wready    <= wready_nxt;
            bvalid    <= bvalid_nxt;
            bresp     <= bresp_nxt;
            arready   <= arready_nxt;
            rvalid    <= rvalid_nxt;
            rdata     <= rdata_nxt;
            rresp     <= rresp_nxt;
        end
    end

    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_first_join: assert property (mode == dfsc_pkg::DFSC_SINGLE |-> en_a == {a_up_r, first_r[`DFSC_FIRST_BIT]})
        else $error("first chain enables differ from the joined code");
    chk_single_first: assert property (mode == dfsc_pkg::DFSC_SINGLE && first_r[`DFSC_FIRST_BIT] |-> en_a[0])
        else $error("first stage off in single mode with bit set");
    chk_dual_first_off: assert property (mode == dfsc_pkg::DFSC_DUAL |-> !en_a[0] && cnt_a <= 4'h8)
        else $error("first stage active in dual mode");
    chk_stage_halves: assert property (g_ch[0].g_st[0].en && ch_v[0][0] && !g_ch[0].g_st[0].ph_r
        |-> !ch_v[0][1] ##1 g_ch[0].g_st[0].ph_r)
        else $error("enabled stage passed the first of a pair");
    chk_max_stages: assert property (cnt_a <= 4'h9 && (mode != dfsc_pkg::DFSC_SINGLE || cnt_b == 4'h0))
        else $error("stage count beyond the mode maximum");
    chk_b_dual_only: assert property (mode != dfsc_pkg::DFSC_DUAL |-> en_b == 9'h000)
        else $error("second chain active outside dual mode");
    chk_dual_gate_off: assert property (mode == dfsc_pkg::DFSC_DUAL && !dspp_r[7] |-> en_a == 9'h000 && en_b == 9'h000)
        else $error("dual decimation active without post-processing enable");
    chk_b_map: assert property (mode == dfsc_pkg::DFSC_DUAL && dspp_r[7] |-> en_b[8:1] == b_r && !en_b[0])
        else $error("second chain stages do not follow its code");
    chk_reset_zero: assert property ($past(!aresetn) |-> a_up_r == 8'h00 && b_r == 8'h00 && !first_r[6])
        else $error("stage codes not zero after reset");
    chk_write_resp: assert property (aw_fire && w_fire |-> ##2 bvalid)
        else $error("write answer not two edges after both taken");
    chk_read_resp: assert property (ar_fire |=> rvalid)
        else $error("read answer late");
    chk_out_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(drain_word))
        else $error("buffer output changed while stalled");

    cov_dual_decim: cover property (mode == dfsc_pkg::DFSC_DUAL && cnt_b != 4'h0 && out_valid && out_b_valid);
    cov_single_nine: cover property (mode == dfsc_pkg::DFSC_SINGLE && cnt_a == 4'h9 && ch_v[0][9]);
    cov_buf_full: cover property (!in_ready ##1 !in_ready);
    cov_write: cover property (do_wr && awaddr_r == `DFSC_ADDR_B);
endmodule // dfsc_top

/* tb/dfsc_core_model.sv */
// converter core model: hands numbered sample pairs to the block under in_valid/in_ready
`timescale 1ns/10ps
module dfsc_core_model (
    // clock and reset
    input  wire logic               aclk,
    input  wire logic               aresetn,
    // burst control from the bench
    input  wire logic               go,
    input  wire logic               gap,
    input  wire logic [15:0]        burst_len,
    output logic                    done,
    // samples toward the block
    output logic                    in_valid,
    output dfsc_pkg::dfsc_sample_t  in_sample_a,
    output dfsc_pkg::dfsc_sample_t  in_sample_b,
    input  wire logic               in_ready
);
    logic [15:0]            k_r, k_nxt, left_r, left_nxt;
    logic                   valid_nxt, take;
    dfsc_pkg::dfsc_sample_t a_nxt, b_nxt;
    assign take = in_valid && in_ready;
    assign done = (left_r == 16'h0000);
    // a pair stands until taken; idle lines flip every cycle so stale data never looks valid
    always_comb begin
        k_nxt = take ? k_r + 16'h0001 : k_r;
        left_nxt = take ? left_r - 16'h0001 : left_r;
        if (go) begin
            k_nxt = 16'h0000;
            left_nxt = burst_len;
        end
        valid_nxt = (left_nxt != 16'h0000) && !(gap && take) && !go;
        a_nxt = valid_nxt ? 16'h0100 + 16'(k_nxt * 3) : ~in_sample_a;
        b_nxt = valid_nxt ? 16'hF000 - 16'(k_nxt * 5) : ~in_sample_b;
    end
    // register the burst state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            k_r <= 16'h0000;
            left_r <= 16'h0000;
            in_valid <= 1'h0;
            in_sample_a <= 16'h0000;
            in_sample_b <= 16'h0000;
        end else begin
            k_r <= k_nxt;
            left_r <= left_nxt;
            in_valid <= valid_nxt;
            in_sample_a <= a_nxt;
            in_sample_b <= b_nxt;
        end
    end
endmodule // dfsc_core_model

/* tb/tb_top.sv */
// self-checking bench for the decimation filter stage control block
`timescale 1ns/10ps
`include "dfsc_defines.svh"
module tb_top;
    logic                   aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic [11:0]            awaddr, araddr;
    logic [31:0]            wdata, rdata;
    logic [3:0]             wstrb;
    logic [1:0]             bresp, rresp;
    logic                   awready, wready, bvalid, arready, rvalid;
    logic                   in_valid, in_ready, out_valid, out_ready, out_a_valid, out_b_valid;
    dfsc_pkg::dfsc_sample_t in_sample_a, in_sample_b, out_sample_a, out_sample_b;
    logic                   go, gap, done;
    logic [15:0]            burst_len;
    logic [15:0]            qa[$], qb[$];
    int                     fails, n_tests;

    dfsc_top dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .in_valid(in_valid), .in_sample_a(in_sample_a),
        .in_sample_b(in_sample_b), .in_ready(in_ready), .out_valid(out_valid), .out_ready(out_ready),
        .out_a_valid(out_a_valid), .out_sample_a(out_sample_a), .out_b_valid(out_b_valid),
        .out_sample_b(out_sample_b));
    dfsc_core_model core (.aclk(aclk), .aresetn(aresetn), .go(go), .gap(gap), .burst_len(burst_len),
        .done(done), .in_valid(in_valid), .in_sample_a(in_sample_a), .in_sample_b(in_sample_b),
        .in_ready(in_ready));

    // 25 MHz clock
    always #20 aclk = ~aclk;

    // collect every lane sample that leaves the buffer
    always @(posedge aclk) begin
        if (aresetn === 1'h1 && out_valid === 1'h1 && out_ready === 1'h1) begin
            if (out_a_valid === 1'h1) qa.push_back(out_sample_a);
            if (out_b_valid === 1'h1) qb.push_back(out_sample_b);
        end
    end

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic timed_out();
        fails++;
        $display("MISMATCH t=%0t wait ran out", $time);
        report_and_stop();
    endtask

    // one write: address and data offered together, each dropped when taken
    task automatic axi_write(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
        int n;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h000000, d};
        wstrb <= 4'hF;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (awvalid === 1'h1 && awready === 1'h1) awvalid <= 1'h0;
            if (wvalid === 1'h1 && wready === 1'h1) wvalid <= 1'h0;
            if (bvalid === 1'h1) break;
        end
        if (n == 100) timed_out();
        bready <= 1'h0;
        check({30'h0, bresp}, {30'h0, er});
    endtask

    task automatic axi_read(input logic [11:0] a, input logic [7:0] ed, input logic [1:0] er);
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (arvalid === 1'h1 && arready === 1'h1) arvalid <= 1'h0;
            if (rvalid === 1'h1) break;
        end
        if (n == 100) timed_out();
        rready <= 1'h0;
        check(rdata, {24'h000000, ed});
        check({30'h0, rresp}, {30'h0, er});
    endtask

    // expected lane sample: pair averages nested n deep, signed and truncating
    function automatic logic signed [16:0] smp(input int lane, input int k);
        logic [15:0] v;
        v = lane ? 16'hF000 - 16'(k * 5) : 16'h0100 + 16'(k * 3);
        return $signed({v[15], v});
    endfunction
    function automatic logic signed [16:0] avg(input int lane, input int k, input int n);
        if (n == 0) return smp(lane, k);
        return (avg(lane, k, n - 1) + avg(lane, k + (1 << (n - 1)), n - 1)) >>> 1;
    endfunction

    // send a burst, optionally stalling the receiver first, then judge both lanes
    task automatic stream(input int total, input int na, input int nb, input logic g, input logic stall);
        int n;
        logic signed [16:0] e;
        qa.delete();
        qb.delete();
        @(posedge aclk);
        gap <= g;
        burst_len <= 16'(total);
        go <= 1'h1;
        out_ready <= !stall;
        @(posedge aclk);
        go <= 1'h0;
        if (stall) begin
            repeat (10) @(posedge aclk);
            check({31'h0, in_ready}, 32'h0);
            check({31'h0, out_valid}, 32'h1);
            out_ready <= 1'h1;
        end
        for (n = 0; n < 3000 && !(n > 2 && done === 1'h1 && out_valid === 1'h0); n++) @(posedge aclk);
        if (n == 3000) timed_out();
        check(32'(qa.size()), 32'(total >> na));
        check(32'(qb.size()), nb < 0 ? 32'h0 : 32'(total >> nb));
        foreach (qa[i]) begin
            e = avg(0, i << na, na);
            check({16'h0, qa[i]}, {16'h0, e[15:0]});
        end
        foreach (qb[i]) begin
            e = avg(1, i << nb, nb);
            check({16'h0, qb[i]}, {16'h0, e[15:0]});
        end
    endtask

    // reset values, read back, status read-only, unmapped place
    task automatic t_regs();
        logic [11:0] tbl[4] = '{`DFSC_ADDR_DSPP, `DFSC_ADDR_FIRST, `DFSC_ADDR_A_UPPER, `DFSC_ADDR_B};
        axi_read(`DFSC_ADDR_MODE, 8'h00, `DFSC_RESP_OKAY);
        foreach (tbl[i]) begin
            axi_read(tbl[i], 8'h00, `DFSC_RESP_OKAY);
            axi_write(tbl[i], 8'hA5, `DFSC_RESP_OKAY);
            axi_read(tbl[i], 8'hA5, `DFSC_RESP_OKAY);
            axi_write(tbl[i], 8'h00, `DFSC_RESP_OKAY);
        end
        axi_write(`DFSC_ADDR_STATUS, 8'hFF, `DFSC_RESP_OKAY);
        axi_read(`DFSC_ADDR_STATUS, 8'h00, `DFSC_RESP_OKAY);
        axi_write(12'h100, 8'h5A, `DFSC_RESP_SLVERR);
        axi_read(12'h100, 8'h00, `DFSC_RESP_SLVERR);
    endtask

    // all-zero codes pass every sample; receiver stall fills the two-entry buffer
    task automatic t_bypass();
        stream(6, 0, -1, 1'h0, 1'h1);
    endtask

    // single mode: first-stage bit plus upper ones, second chain ignored
    task automatic t_single();
        int ns[3] = '{1, 3, 9};
        axi_write(`DFSC_ADDR_FIRST, 8'h40, `DFSC_RESP_OKAY);
        axi_write(`DFSC_ADDR_B, 8'h03, `DFSC_RESP_OKAY);
        foreach (ns[i]) begin
            axi_write(`DFSC_ADDR_A_UPPER, 8'((1 << (ns[i] - 1)) - 1), `DFSC_RESP_OKAY);
            axi_read(`DFSC_ADDR_STATUS, 8'(ns[i]), `DFSC_RESP_OKAY);
            stream(ns[i] == 9 ? 512 : 2 << ns[i], ns[i], -1, ns[i] == 3, 1'h0);
        end
    endtask

    // dual mode: first stage forced off, second chain active once post-processing is on
    task automatic t_dual();
        axi_write(`DFSC_ADDR_MODE, 8'h01, `DFSC_RESP_OKAY);
        axi_read(`DFSC_ADDR_STATUS, 8'h00, `DFSC_RESP_OKAY);
        axi_write(`DFSC_ADDR_DSPP, 8'h80, `DFSC_RESP_OKAY);
        axi_write(`DFSC_ADDR_A_UPPER, 8'hFF, `DFSC_RESP_OKAY);
        axi_write(`DFSC_ADDR_B, 8'hFF, `DFSC_RESP_OKAY);
        axi_read(`DFSC_ADDR_STATUS, 8'h88, `DFSC_RESP_OKAY);
        axi_write(`DFSC_ADDR_B, 8'h7F, `DFSC_RESP_OKAY);
        axi_read(`DFSC_ADDR_STATUS, 8'h78, `DFSC_RESP_OKAY);
        axi_write(`DFSC_ADDR_A_UPPER, 8'h01, `DFSC_RESP_OKAY);
        axi_write(`DFSC_ADDR_B, 8'h03, `DFSC_RESP_OKAY);
        axi_read(`DFSC_ADDR_STATUS, 8'h21, `DFSC_RESP_OKAY);
        stream(8, 1, 2, 1'h0, 1'h0);
        // the undefined mode code bypasses both chains, both lanes pass through
        axi_write(`DFSC_ADDR_MODE, 8'h02, `DFSC_RESP_OKAY);
        axi_read(`DFSC_ADDR_STATUS, 8'h00, `DFSC_RESP_OKAY);
        stream(4, 0, 0, 1'h0, 1'h0);
    endtask

    // main sequence
    initial begin
        {aclk, awvalid, wvalid, bready, arvalid, rready, go, gap} = '0;
        {awaddr, araddr, wdata, wstrb, burst_len} = '0;
        out_ready = 1'h1;
        fails = 0;
        n_tests = 0;
        aresetn = 1'h0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'h1;
        t_regs();
        t_bypass();
        t_single();
        t_dual();
        report_and_stop();
    end
endmodule // tb_top
